/* core/tes_pkg.sv */
// Package: constants and types of the trap entry and return sequencer
package tes_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] TES_IDX_CUR_STATUS = 8'h01;
    localparam logic [7:0] TES_IDX_SAVED_STATUS = 8'h02;
    localparam logic [7:0] TES_IDX_VECTOR_BASE = 8'h03;
    localparam logic [7:0] TES_IDX_CHAN_CTRL = 8'h04;
    localparam logic [7:0] TES_IDX_DECODE_PC = 8'h0a;
    localparam logic [7:0] TES_IDX_EXECUTE_PC = 8'h0b;
    localparam logic [7:0] TES_IDX_WRITEBACK_PC = 8'h0c;
    // Status fields
    localparam int TES_ST_FREEZE = 0;
    localparam int TES_ST_DISABLE_ALL = 1;
    localparam int TES_ST_DISABLE_INT = 2;
    localparam int TES_ST_MASK_LO = 3;
    localparam int TES_ST_WIDTH = 5;
    localparam logic [4:0] TES_ST_RESET = 5'h07;
    // Channel control fields
    localparam int TES_CH_VALID = 0;
    localparam int TES_CH_NOT_NEEDED = 1;
    localparam int TES_CH_MULTIPLE = 2;
    localparam logic [2:0] TES_CH_RESET = 3'h0;
    localparam logic [31:0] TES_VBASE_RESET = 32'h0000_0000;
    localparam logic [29:0] TES_PC_RESET = 30'h0000_0000;
    // AHB encodings
    localparam logic [1:0] TES_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] TES_ACCESS_WORD = 3'h2;
    typedef enum logic [3:0] {
        TES_IDLE, TES_E_SUSP_EXEC, TES_E_SUSP_FETCH, TES_E_DRAIN, TES_E_SAVE,
        TES_E_STATUS, TES_E_VECTOR, TES_E_FETCH, TES_R_WAIT, TES_R_INV,
        TES_R_STATUS, TES_R_SINGLE, TES_R_FETCH1, TES_R_FETCH0, TES_R_MULTI,
        TES_R_ENABLE
    } tes_state_type;
endpackage

/* core/tes_sequencer.sv */
// Module: trap entry and return sequencer with AHB-Lite register slave
// How it works
// RULE1 - Decode history loads unless frozen
// RULE2 - Execute history loads unless frozen
// RULE3 - Writeback history loads unless frozen, report only
// RULE4 - History low two bits read zero
// RULE5 - Suspend execution, then fetching, first
// RULE6 - Finish load/store, cancel multiple remainder
// RULE7 - Save status before modifying it
// RULE8 - Entry sets freeze; frozen registers hold
// RULE9 - Vector read: base plus number, word data
// RULE10 - Fetch handler from vector, then resume
// RULE11 - No register saving to memory
// RULE12 - Handler saves state, clears freeze early
// RULE13 - Invalidating return clears unlocked valid bits
// RULE14 - Return waits for load/store and multiple
// RULE15 - Traps blocked from invalidation through refill
// RULE16 - Return copies saved status to current
// RULE17 - Restart single access when valid, single
// RULE18 - Fetch execute history as branch first
// RULE19 - Then fetch decode history as branch
// RULE20 - Restart multiple after refill when flagged
// RULE21 - Re-enable traps per status, resume
// RULE22 - Software preloads status, channel, history
module tes_sequencer
    import tes_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic decode_enter,
    input wire logic [31:0] decode_addr,
    input wire logic execute_enter,
    input wire logic [31:0] execute_addr,
    input wire logic writeback_enter,
    input wire logic [31:0] writeback_addr,
    input wire logic chan_update,
    input wire logic [2:0] chan_ctrl_in,
    input wire logic trap_req,
    input wire logic [7:0] trap_vector,
    input wire logic return_from_trap,
    input wire logic return_and_invalidate_cache,
    input wire logic access_busy,
    input wire logic multiple_busy,
    output logic exec_suspend,
    output logic fetch_suspend,
    output logic cancel_multiple,
    output logic vec_req,
    output logic [31:0] vec_addr,
    output logic [2:0] access_size_option,
    input wire logic vec_ack,
    input wire logic [31:0] vec_data,
    output logic fetch_req,
    output logic [31:0] fetch_addr,
    output logic fetch_branch,
    input wire logic fetch_ack,
    output logic decode_load,
    output logic execute_load,
    output logic icache_invalidate,
    output logic restart_single,
    output logic restart_multiple,
    output logic trap_block,
    output logic handler_start,
    output logic freeze_flag,
    output logic [TES_ST_WIDTH-1:0] cur_status
);
    tes_state_type state_r;
    tes_state_type state_nxt;
    logic [TES_ST_WIDTH-1:0] cur_status_r;
    logic [TES_ST_WIDTH-1:0] saved_status_r;
    logic [31:0] vector_base_r;
    logic [2:0] chan_ctrl_r;
    logic [29:0] decode_pc_r;
    logic [29:0] execute_pc_r;
    logic [29:0] writeback_pc_r;
    logic inv_pend_r;
    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] acc_idx_r;
    logic exec_suspend_r;
    logic fetch_suspend_r;
    logic cancel_multiple_r;
    logic vec_req_r;
    logic [31:0] vec_addr_r;
    logic fetch_req_r;
    logic [31:0] fetch_addr_r;
    logic fetch_branch_r;
    logic decode_load_r;
    logic execute_load_r;
    logic icache_inv_r;
    logic restart_single_r;
    logic restart_multiple_r;
    logic trap_block_r;
    logic handler_start_r;

    // Bus decode
    wire addr_phase = hsel && hready && (htrans == TES_HTRANS_NONSEQ);
    wire [7:0] addr_idx = haddr[9:2];
    wire wr_cur = wr_pend_r && (acc_idx_r == TES_IDX_CUR_STATUS);
    wire wr_saved = wr_pend_r && (acc_idx_r == TES_IDX_SAVED_STATUS);
    wire wr_vbase = wr_pend_r && (acc_idx_r == TES_IDX_VECTOR_BASE);
    wire wr_chan = wr_pend_r && (acc_idx_r == TES_IDX_CHAN_CTRL);
    wire wr_dpc = wr_pend_r && (acc_idx_r == TES_IDX_DECODE_PC);
    wire wr_epc = wr_pend_r && (acc_idx_r == TES_IDX_EXECUTE_PC);
    wire wr_wpc = wr_pend_r && (acc_idx_r == TES_IDX_WRITEBACK_PC);
    wire frozen = cur_status_r[TES_ST_FREEZE];
    wire [31:0] rd_mux =
        (acc_idx_r == TES_IDX_CUR_STATUS) ? {27'h000_0000, cur_status_r} :
        (acc_idx_r == TES_IDX_SAVED_STATUS) ? {27'h000_0000, saved_status_r} :
        (acc_idx_r == TES_IDX_VECTOR_BASE) ? vector_base_r :
        (acc_idx_r == TES_IDX_CHAN_CTRL) ? {29'h0000_0000, chan_ctrl_r} :
        (acc_idx_r == TES_IDX_DECODE_PC) ? {decode_pc_r, 2'b00} : // RULE4
        (acc_idx_r == TES_IDX_EXECUTE_PC) ? {execute_pc_r, 2'b00} : // RULE4
        (acc_idx_r == TES_IDX_WRITEBACK_PC) ? {writeback_pc_r, 2'b00} : // RULE4
        32'h0000_0000;

    // Sequencer conditions
    wire take_trap = (state_r == TES_IDLE) && trap_req && !cur_status_r[TES_ST_DISABLE_ALL];
    wire take_ret = (state_r == TES_IDLE) && !take_trap &&
        (return_from_trap || return_and_invalidate_cache);
    wire chan_single = chan_ctrl_r[TES_CH_VALID] && !chan_ctrl_r[TES_CH_NOT_NEEDED] &&
        !chan_ctrl_r[TES_CH_MULTIPLE];
    wire chan_multi = chan_ctrl_r[TES_CH_VALID] && !chan_ctrl_r[TES_CH_NOT_NEEDED] &&
        chan_ctrl_r[TES_CH_MULTIPLE];
    // Vector number scaled to a word offset; an OR would alias unaligned bases
    wire [31:0] vec_phys = vector_base_r + {22'h00_0000, trap_vector, 2'b00}; // RULE9
    wire [TES_ST_WIDTH-1:0] entry_status = cur_status_r |
        (5'h01 << TES_ST_FREEZE) | (5'h01 << TES_ST_DISABLE_ALL) |
        (5'h01 << TES_ST_DISABLE_INT);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TES_IDLE: begin
                if (take_trap) begin
                    state_nxt = TES_E_SUSP_EXEC;
                end else if (take_ret) begin
                    state_nxt = TES_R_WAIT;
                end
            end
            TES_E_SUSP_EXEC: state_nxt = TES_E_SUSP_FETCH; // RULE5
            TES_E_SUSP_FETCH: state_nxt = TES_E_DRAIN; // RULE5
            TES_E_DRAIN: begin
                if (!access_busy) begin
                    state_nxt = TES_E_SAVE; // RULE6
                end
            end
            TES_E_SAVE: state_nxt = TES_E_STATUS;
            TES_E_STATUS: state_nxt = TES_E_VECTOR;
            TES_E_VECTOR: begin
                if (vec_req_r && vec_ack) begin
                    state_nxt = TES_E_FETCH;
                end
            end
            TES_E_FETCH: begin
                if (fetch_req_r && fetch_ack) begin
                    state_nxt = TES_IDLE; // RULE10
                end
            end
            TES_R_WAIT: begin
                if (!access_busy && !multiple_busy) begin
                    state_nxt = TES_R_INV; // RULE14
                end
            end
            TES_R_INV: state_nxt = TES_R_STATUS;
            TES_R_STATUS: state_nxt = TES_R_SINGLE;
            TES_R_SINGLE: state_nxt = TES_R_FETCH1;
            TES_R_FETCH1: begin
                if (fetch_req_r && fetch_ack) begin
                    state_nxt = TES_R_FETCH0;
                end
            end
            TES_R_FETCH0: begin
                if (fetch_req_r && fetch_ack) begin
                    state_nxt = TES_R_MULTI;
                end
            end
            TES_R_MULTI: state_nxt = TES_R_ENABLE;
            TES_R_ENABLE: state_nxt = TES_IDLE; // RULE21
            default: state_nxt = TES_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= TES_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // AHB slave; reads take one wait state so hrdata comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            acc_idx_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_phase && hwrite;
            rd_pend_r <= addr_phase && !hwrite;
            hreadyout_r <= !(addr_phase && !hwrite);
            if (addr_phase) begin
                acc_idx_r <= addr_idx;
            end
            if (rd_pend_r) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // Status: hardware sequencing wins over a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_status_r <= TES_ST_RESET;
            saved_status_r <= TES_ST_RESET;
            vector_base_r <= TES_VBASE_RESET;
        end else begin
            if (state_r == TES_E_SAVE) begin
                saved_status_r <= cur_status_r; // RULE7
            end else if (wr_saved) begin
                saved_status_r <= hwdata[TES_ST_WIDTH-1:0]; // RULE22
            end
            if (state_r == TES_E_STATUS) begin
                cur_status_r <= entry_status; // RULE7 RULE8
            end else if (state_r == TES_R_STATUS) begin
                cur_status_r <= saved_status_r; // RULE16
            end else if (wr_cur) begin
                cur_status_r <= hwdata[TES_ST_WIDTH-1:0]; // RULE12 RULE22
            end
            if (wr_vbase) begin
                vector_base_r <= hwdata;
            end
        end
    end

    // Frozen registers; software may still load them for a return
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_ctrl_r <= TES_CH_RESET;
            decode_pc_r <= TES_PC_RESET;
            execute_pc_r <= TES_PC_RESET;
            writeback_pc_r <= TES_PC_RESET;
        end else begin
            if (wr_chan) begin
                chan_ctrl_r <= hwdata[2:0];
            end else if (chan_update && !frozen) begin
                chan_ctrl_r <= chan_ctrl_in; // RULE8
            end
            if (wr_dpc) begin
                decode_pc_r <= hwdata[31:2];
            end else if (decode_enter && !frozen) begin
                decode_pc_r <= decode_addr[31:2]; // RULE1
            end
            if (wr_epc) begin
                execute_pc_r <= hwdata[31:2];
            end else if (execute_enter && !frozen) begin
                execute_pc_r <= execute_addr[31:2]; // RULE2
            end
            if (wr_wpc) begin
                writeback_pc_r <= hwdata[31:2];
            end else if (writeback_enter && !frozen) begin
                writeback_pc_r <= writeback_addr[31:2]; // RULE3
            end
        end
    end

    // Pipeline, cache and bus controls; nothing is ever written to memory
    always_ff @(posedge hclk or negedge hresetn) begin // RULE11
        if (!hresetn) begin
            exec_suspend_r <= 1'b0;
            fetch_suspend_r <= 1'b0;
            cancel_multiple_r <= 1'b0;
            vec_req_r <= 1'b0;
            vec_addr_r <= 32'h0000_0000;
            fetch_req_r <= 1'b0;
            fetch_addr_r <= 32'h0000_0000;
            fetch_branch_r <= 1'b0;
            decode_load_r <= 1'b0;
            execute_load_r <= 1'b0;
            icache_inv_r <= 1'b0;
            inv_pend_r <= 1'b0;
            restart_single_r <= 1'b0;
            restart_multiple_r <= 1'b0;
            trap_block_r <= 1'b0;
            handler_start_r <= 1'b0;
        end else begin
            cancel_multiple_r <= (state_r == TES_E_SUSP_FETCH); // RULE6
            icache_inv_r <= (state_r == TES_R_INV) && inv_pend_r; // RULE13
            restart_single_r <= (state_r == TES_R_SINGLE) && chan_single; // RULE17
            restart_multiple_r <= (state_r == TES_R_MULTI) && chan_multi; // RULE20
            handler_start_r <= (state_r == TES_E_FETCH) && fetch_req_r && fetch_ack; // RULE10
            execute_load_r <= 1'b0;
            decode_load_r <= 1'b0;
            if (take_ret) begin
                inv_pend_r <= return_and_invalidate_cache;
            end
            if (state_r == TES_E_SUSP_EXEC) begin
                exec_suspend_r <= 1'b1; // RULE5
            end
            if (state_r == TES_E_SUSP_FETCH) begin
                fetch_suspend_r <= 1'b1; // RULE5
            end
            if (state_r == TES_R_WAIT && state_nxt == TES_R_INV) begin
                trap_block_r <= 1'b1; // RULE15
                exec_suspend_r <= 1'b1;
                fetch_suspend_r <= 1'b1;
            end
            if (state_r == TES_R_MULTI) begin
                trap_block_r <= 1'b0; // RULE15 RULE21
            end
            if (state_r == TES_E_STATUS) begin
                vec_req_r <= 1'b1; // RULE9
                vec_addr_r <= {vec_phys[31:2], 2'b00};
            end
            if (state_r == TES_E_VECTOR && vec_req_r && vec_ack) begin
                vec_req_r <= 1'b0;
                fetch_req_r <= 1'b1; // RULE10
                fetch_addr_r <= {vec_data[31:2], 2'b00};
                fetch_branch_r <= 1'b1;
            end
            if (state_r == TES_R_SINGLE) begin
                fetch_req_r <= 1'b1; // RULE18
                fetch_addr_r <= {execute_pc_r, 2'b00};
                fetch_branch_r <= 1'b1;
            end
            if (state_r == TES_R_FETCH1 && fetch_req_r && fetch_ack) begin
                execute_load_r <= 1'b0;
                decode_load_r <= 1'b1; // RULE18
                fetch_addr_r <= {decode_pc_r, 2'b00}; // RULE19
            end
            if (state_r == TES_R_FETCH0 && fetch_req_r && fetch_ack) begin
                fetch_req_r <= 1'b0;
                fetch_branch_r <= 1'b0;
                execute_load_r <= 1'b1; // RULE19
                decode_load_r <= 1'b1;
            end
            if (state_r == TES_E_FETCH && fetch_req_r && fetch_ack) begin
                fetch_req_r <= 1'b0;
                fetch_branch_r <= 1'b0;
                exec_suspend_r <= 1'b0;
                fetch_suspend_r <= 1'b0;
            end
            if (state_r == TES_R_ENABLE) begin
                exec_suspend_r <= 1'b0; // RULE21
                fetch_suspend_r <= 1'b0;
            end
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = 1'b0;
    assign exec_suspend = exec_suspend_r;
    assign fetch_suspend = fetch_suspend_r;
    assign cancel_multiple = cancel_multiple_r;
    assign vec_req = vec_req_r;
    assign vec_addr = vec_addr_r;
    assign access_size_option = TES_ACCESS_WORD;
    assign fetch_req = fetch_req_r;
    assign fetch_addr = fetch_addr_r;
    assign fetch_branch = fetch_branch_r;
    assign decode_load = decode_load_r;
    assign execute_load = execute_load_r;
    assign icache_invalidate = icache_inv_r;
    assign restart_single = restart_single_r;
    assign restart_multiple = restart_multiple_r;
    assign trap_block = trap_block_r;
    assign handler_start = handler_start_r;
    assign freeze_flag = cur_status_r[TES_ST_FREEZE];
    assign cur_status = cur_status_r;

    // Checks
    sequence entry_start_s;
        state_r == TES_IDLE && take_trap;
    endsequence
    sequence suspend_order_s;
        ##1 exec_suspend_r == 1'b0 ##1 exec_suspend_r && !fetch_suspend_r ##1 fetch_suspend_r;
    endsequence
    suspend_order_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
        entry_start_s |-> suspend_order_s)
        else $error("suspend order wrong");
    freeze_decode_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        frozen && !wr_dpc |=> $stable(decode_pc_r))
        else $error("decode history moved while frozen");
    load_execute_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        !frozen && execute_enter && !wr_epc |=> execute_pc_r == $past(execute_addr[31:2]))
        else $error("execute history not loaded");
    freeze_wb_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        frozen && !wr_wpc |=> $stable(writeback_pc_r))
        else $error("writeback history moved while frozen");
    save_status_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        state_r == TES_E_SAVE |=> saved_status_r == $past(cur_status_r) ##1 frozen)
        else $error("status not saved before freeze");
    vector_word_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        vec_req_r |-> access_size_option == TES_ACCESS_WORD && vec_addr_r[1:0] == 2'b00)
        else $error("vector read not word sized");
    return_wait_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
        state_r == TES_R_WAIT && (access_busy || multiple_busy) |=> state_r == TES_R_WAIT)
        else $error("return ran during access");
    block_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE15
        state_r inside {TES_R_STATUS, TES_R_SINGLE, TES_R_FETCH1, TES_R_FETCH0} |-> trap_block_r)
        else $error("traps not blocked in return");
    restore_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE16
        state_r == TES_R_STATUS |=> cur_status_r == $past(saved_status_r))
        else $error("status not restored");
    inv_plain_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE13
        icache_inv_r |-> inv_pend_r && $past(state_r) == TES_R_INV)
        else $error("cache invalidated wrongly");
    single_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE17
        state_r == TES_R_SINGLE |=> restart_single_r == $past(chan_single))
        else $error("single restart mismatch");
    multi_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE20
        restart_multiple_r |-> $past(chan_multi) && $past(state_r) == TES_R_MULTI)
        else $error("multiple restart mismatch");
endmodule

/* tb/tes_far_side.sv */
// Behavioural model of the pipeline, cache and bus side
module tes_far_side #(
    parameter logic [31:0] VEC_XOR = 32'h5a5a_a5a7
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] dly,
    input wire logic vec_req,
    input wire logic [31:0] vec_addr,
    input wire logic fetch_req,
    output logic vec_ack,
    output logic [31:0] vec_data,
    output logic fetch_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] vcnt;
    logic [1:0] fcnt;
    wire vgo = vec_req && !vec_ack && vcnt == dly;
    wire fgo = fetch_req && !fetch_ack && fcnt == dly;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vec_ack <= 1'b0;
            fetch_ack <= 1'b0;
            vcnt <= 2'h0;
            fcnt <= 2'h0;
            vec_data <= 32'h0000_0000;
        end else begin
            // One ack per request, after a stall of dly cycles
            vec_ack <= vgo;
            fetch_ack <= fgo;
            vcnt <= (vec_req && !vec_ack && !vgo) ? vcnt + 2'h1 : 2'h0;
            fcnt <= (fetch_req && !fetch_ack && !fgo) ? fcnt + 2'h1 : 2'h0;
            // Toggle outside the ack so a stale sample never matches
            vec_data <= vgo ? (vec_addr ^ VEC_XOR) : ~vec_data;
        end
    end
endmodule

/* tb/trap_entry_return_sequencer_tb.sv */
// Self-checking bench of the trap entry and return sequencer
module trap_entry_return_sequencer_tb;
    import tes_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] VX = 32'h5a5a_a5a7;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, trap_req, rft, rinv;
    logic [31:0] haddr, hwdata, hrdata, pa, vec_addr, vec_data, fetch_addr, a, b;
    logic [1:0] htrans, dly;
    logic [2:0] hsize, aso;
    logic [7:0] tv;
    logic dec_en, exe_en, wb_en, abusy, mbusy, es, fs, cm, vreq, vack, freq, fbr, fack;
    logic dl, el, inv, rs, rm, tblk, hs, frz, rd_dp;
    logic [4:0] cst;
    logic [31:0] rdq[$], aq[$];
    int error_cnt = 0, total_checks = 0, cyc = 0, n_inv, n_rs, n_rm, n_hs, n_cm, n_dl, n_el;
    assign hready = hreadyout;
    tes_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .decode_enter(dec_en),
        .decode_addr(pa), .execute_enter(exe_en), .execute_addr(pa), .writeback_enter(wb_en),
        .writeback_addr(pa), .chan_update(dec_en), .chan_ctrl_in(pa[2:0]), .trap_req(trap_req),
        .trap_vector(tv), .return_from_trap(rft), .return_and_invalidate_cache(rinv),
        .access_busy(abusy), .multiple_busy(mbusy), .exec_suspend(es), .fetch_suspend(fs),
        .cancel_multiple(cm), .vec_req(vreq), .vec_addr(vec_addr), .access_size_option(aso),
        .vec_ack(vack), .vec_data(vec_data), .fetch_req(freq), .fetch_addr(fetch_addr),
        .fetch_branch(fbr), .fetch_ack(fack), .decode_load(dl), .execute_load(el),
        .icache_invalidate(inv), .restart_single(rs), .restart_multiple(rm),
        .trap_block(tblk), .handler_start(hs), .freeze_flag(frz), .cur_status(cst));
    tes_far_side #(.VEC_XOR(VX)) far (.hclk(hclk), .hresetn(hresetn), .dly(dly),
        .vec_req(vreq), .vec_addr(vec_addr), .fetch_req(freq), .vec_ack(vack),
        .vec_data(vec_data), .fetch_ack(fack));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hold the address phase, then the data phase, each until hready
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= TES_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h00_0000, idx, 2'b00};
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) rdq.push_back(d);
        @(posedge hclk);
        while (!hready) @(posedge hclk);
    endtask
    task automatic pipe(input logic [31:0] x);
        pa <= x;
        {dec_en, exe_en, wb_en} <= 3'h7;
        @(posedge hclk);
        {dec_en, exe_en, wb_en} <= 3'h0;
        @(posedge hclk);
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
        if (rd_dp && hreadyout) begin
            chk("hrdata", rdq.pop_front(), hrdata);
            rd_dp = 1'b0;
        end
        if (hsel && htrans == TES_HTRANS_NONSEQ && !hwrite && hready) rd_dp = 1'b1;
        if (vreq && vack) chk("vec_addr", aq.pop_front(), vec_addr);
        if (vreq && vack) chk("size_opt", TES_ACCESS_WORD, aso);
        if (freq && fack) chk("fetch_addr", aq.pop_front(), fetch_addr);
        if (freq && fack && tblk) chk("branch", 1, fbr);
        if (fs && !es) chk("suspend_order", 1, 0);
        if (vreq && abusy) chk("drain", 1, 0);
        if (inv && mbusy) chk("ret_wait", 1, 0);
        if ((inv || dl) && !tblk) chk("blocked", 1, 0);
        {n_inv, n_rs, n_rm, n_hs} = {n_inv + inv, n_rs + rs, n_rm + rm, n_hs + hs};
        {n_cm, n_dl, n_el} = {n_cm + cm, n_dl + dl, n_el + el};
    end
    initial begin
        {hresetn, hsel, hwrite, trap_req, rft, rinv, dec_en, exe_en, wb_en} = 9'h000;
        {abusy, mbusy, rd_dp, htrans, tv, dly} = 15'h0000;
        {haddr, hwdata, pa} = {3{32'h0000_0000}};
        hsize = TES_ACCESS_WORD;
        void'($urandom(75));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, TES_IDX_CUR_STATUS, {27'h0, TES_ST_RESET});
        bus(0, 8'h3f, 32'h0000_0000);
        pipe($urandom);
        bus(0, TES_IDX_DECODE_PC, 32'h0000_0000);
        $display("reset test done");
        a = $urandom;
        bus(1, TES_IDX_CUR_STATUS, 32'h0000_0000);
        pipe(a);
        bus(0, TES_IDX_DECODE_PC, {a[31:2], 2'b00});
        bus(0, TES_IDX_EXECUTE_PC, {a[31:2], 2'b00});
        bus(0, TES_IDX_WRITEBACK_PC, {a[31:2], 2'b00});
        bus(1, TES_IDX_CUR_STATUS, 32'h0000_0001);
        pipe(~a);
        bus(0, TES_IDX_EXECUTE_PC, {a[31:2], 2'b00});
        bus(0, TES_IDX_CHAN_CTRL, a & 32'h7);
        $display("history test done");
        bus(1, TES_IDX_CUR_STATUS, 32'h0000_0018);
        b = $urandom & 32'hffff_fffc;
        bus(1, TES_IDX_VECTOR_BASE, b);
        {n_hs, n_cm} = 64'h0;
        tv <= 8'($urandom);
        dly <= 2'h2;
        @(posedge hclk);
        aq.push_back(b + {22'h0, tv, 2'b00});
        aq.push_back((b + {22'h0, tv, 2'b00}) ^ VX & 32'hffff_fffc);
        trap_req <= 1'b1;
        abusy <= 1'b1;
        repeat (6) @(posedge hclk);
        abusy <= 1'b0;
        while (!hs) @(posedge hclk);
        trap_req <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("cancel", 1, n_cm);
        chk("handler", 1, n_hs);
        chk("freeze", 1, frz);
        chk("cur_status", 32'h1f, cst);
        bus(0, TES_IDX_SAVED_STATUS, 32'h0000_0018);
        bus(0, TES_IDX_CUR_STATUS, 32'h0000_001f);
        $display("entry test done");
        for (int i = 0; i < 3; i++) begin
            a = $urandom;
            b = $urandom;
            dly <= 2'($urandom);
            bus(1, TES_IDX_CUR_STATUS, 32'h0000_0001);
            bus(1, TES_IDX_SAVED_STATUS, 32'h0000_0008);
            bus(1, TES_IDX_CHAN_CTRL, i == 0 ? 32'h1 : i == 1 ? 32'h5 : 32'h3);
            bus(1, TES_IDX_EXECUTE_PC, a);
            bus(1, TES_IDX_DECODE_PC, b);
            aq.push_back({a[31:2], 2'b00});
            aq.push_back({b[31:2], 2'b00});
            {n_inv, n_rs, n_rm, n_dl, n_el} = 160'h0;
            mbusy <= 1'b1;
            rinv <= i != 1;
            rft <= i == 1;
            @(posedge hclk);
            {rinv, rft} <= 2'h0;
            repeat (3) @(posedge hclk);
            mbusy <= 1'b0;
            while (!tblk) @(posedge hclk);
            while (tblk) @(posedge hclk);
            repeat (3) @(posedge hclk);
            chk("invalidate", i != 1, n_inv);
            chk("single", i == 0, n_rs);
            chk("multiple", i == 1, n_rm);
            chk("dec_load", 2, n_dl);
            chk("exe_load", 1, n_el);
            bus(0, TES_IDX_CUR_STATUS, 32'h0000_0008);
            $display("return test %0d done", i);
        end
        report_and_stop();
    end
endmodule
